/* src/qpp_pair_buf.sv */
module qpp_pair_buf #(
  parameter int W = 16,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic reset,
  qpp_stream_if.snk up,
  qpp_stream_if.src dn
);

  localparam int CW = $clog2(DEPTH + 1);

  logic [DEPTH-1:0][W-1:0] slot;
  logic [DEPTH-1:0][W-1:0] next_slot;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic push;
  logic pop;
  logic [CW-1:0] wr_idx;

  assign up.ready = (cnt != CW'(DEPTH));
  assign dn.valid = (cnt != '0);
  assign dn.data = slot[0];
  assign push = up.valid & up.ready;
  assign pop = dn.valid & dn.ready;
  assign wr_idx = pop ? CW'(cnt - 1'b1) : cnt;

  // ==========================================================================
  // Shift-out buffer: the head always sits in slot 0.
  // ==========================================================================
  always_comb begin
    next_slot = slot;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_slot[i] = slot[i+1];
      end
    end
    if (push) begin
      next_slot[wr_idx] = up.data;
    end
    next_cnt = CW'(cnt + CW'(push) - CW'(pop));
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      slot <= '0;
      cnt <= '0;
    end else begin
      slot <= next_slot;
      cnt <= next_cnt;
    end
  end

  a_buf_no_overflow: assert property (@(posedge core_clk) disable iff (reset)
    cnt <= CW'(DEPTH)) else $error("pair buffer count beyond depth");

endmodule

/* src/qpp_pkg.sv */
package qpp_pkg;

  // ==========================================================================
  // Geometry of the ports and of the interrupt groups.
  // ==========================================================================
  localparam int NPORT = 4;
  localparam int DW = 16;
  localparam int GRP_W = 8;
  localparam int NGRP = 2;
  localparam int BUF_DEPTH = 2;

  // ==========================================================================
  // Host register selection: bit 2 picks the data buffer, bits 1:0 the port.
  // ==========================================================================
  localparam int ADDR_W = 3;
  localparam int ADDR_KIND_BIT = 2;
  localparam logic [1:0] BE_WORD = 2'h3;

  // ==========================================================================
  // Control/status word layout.
  // ==========================================================================
  localparam int BIT_DIR = 8;
  localparam int BIT_IE = 9;
  localparam int BIT_RDY = 15;
  localparam int CMD_SEL_LSB = 0;
  localparam int CMD_IDX_LSB = 3;

  // ==========================================================================
  // Values after reset.
  // ==========================================================================
  localparam logic [15:0] IMR_RST = 16'hffff;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Internal register reached through a group's data byte.
  typedef enum logic [2:0] {
    QPP_T_REQ = 3'h0,
    QPP_T_ISR = 3'h1,
    QPP_T_ACR = 3'h2,
    QPP_T_IMR = 3'h3,
    QPP_T_VEC = 3'h4
  } qpp_target_e;

  // Lowest set bit of a request word, with a found flag on top.
  function automatic logic [4:0] qpp_lowest(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

endpackage

/* src/qpp_stream_if.sv */
interface qpp_stream_if #(parameter int W = 16) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

/* src/qpp_top.sv */
// ============================================================================
// Operation
// R1: four ports of sixteen three-state lines
// R2: writes drive latches, reads come from pins
// R3: per-port control/status over shared internal bus
// R4: control/status readable, writable, byte addressable
// R5: data buffer is accessed as whole word
// R6: output mode read returns output latch
// R7: output latches survive bus initialize
// R8: port A lines form two eight-line groups
// R9: sixteen request lines, one vector each
// R10: group command byte kept through bus initialize
// R11: direction clear asserts near ready; initialize clears
// R12: drive only with direction and user ready
// R13: otherwise data lines stay released
// R14: bit 9 gates interrupts; initialize clears it
// R15: bit 15 reads live user ready
// R16: user asserts ready to receive output data
// R17: two control lines out, two in
// R18: data byte reaches command-selected internal register
// R19: bits 14:10 read zero, writes ignored
// ============================================================================
module qpp_top (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic bus_initialize,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_be,
  input wire logic [15:0] reg_wdata,
  output logic reg_wready,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [3:0][15:0] port_din,
  output logic [3:0][15:0] port_dout,
  output logic [3:0][15:0] port_doe,
  input wire logic [3:0] user_ready,
  input wire logic [3:0] user_strobe,
  output logic [3:0] near_side_ready,
  output logic [3:0] data_strobe,
  input wire logic irq_ack,
  output logic irq_req,
  output logic [7:0] irq_vector
);

  localparam int NP = qpp_pkg::NPORT;
  localparam int DW = qpp_pkg::DW;

  // ==========================================================================
  // Pin synchronisers.
  // ==========================================================================
  logic [NP-1:0][DW-1:0] din_s1, din_s2;
  logic [DW-1:0] line_a_s3;
  logic [NP-1:0] urdy_s1, urdy_s2, ustb_s1, ustb_s2, ustb_s3;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      din_s1 <= '0;
      din_s2 <= '0;
      line_a_s3 <= '0;
      urdy_s1 <= '0;
      urdy_s2 <= '0;
      ustb_s1 <= '0;
      ustb_s2 <= '0;
      ustb_s3 <= '0;
    end else begin
      din_s1 <= port_din;
      din_s2 <= din_s1;
      line_a_s3 <= din_s2[0];
      urdy_s1 <= user_ready;
      urdy_s2 <= urdy_s1;
      ustb_s1 <= user_strobe;
      ustb_s2 <= ustb_s1;
      ustb_s3 <= ustb_s2;
    end
  end

  logic [NP-1:0] ustb_rise;
  logic [DW-1:0] req_edge;
  assign ustb_rise = ustb_s2 & ~ustb_s3;
  assign req_edge = din_s2[0] & ~line_a_s3; // R8 R9

  // ==========================================================================
  // Host access decode.
  // ==========================================================================
  logic [1:0] sel_p;
  logic is_dbr;
  logic [NP-1:0] csr_wr, dbr_wr, push, up_ready;
  assign sel_p = reg_addr[1:0];
  assign is_dbr = reg_addr[qpp_pkg::ADDR_KIND_BIT];
  assign reg_wready = is_dbr ? up_ready[sel_p] : 1'b1;

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      csr_wr[p] = reg_wr & reg_wready & ~is_dbr & (sel_p == 2'(p)); // R3
      dbr_wr[p] = reg_wr & reg_wready & is_dbr & (sel_p == 2'(p));
      push[p] = dbr_wr[p] & (reg_be == qpp_pkg::BE_WORD); // R5
    end
  end

  // ==========================================================================
  // Direction and master enable.
  // ==========================================================================
  logic [NP-1:0] dir, next_dir;
  logic ie, next_ie;

  always_comb begin
    next_dir = dir;
    next_ie = ie;
    for (int p = 0; p < NP; p++) begin
      if (csr_wr[p] && reg_be[1]) begin
        next_dir[p] = reg_wdata[qpp_pkg::BIT_DIR]; // R4
      end
    end
    if (csr_wr[0] && reg_be[1]) begin
      next_ie = reg_wdata[qpp_pkg::BIT_IE]; // R14
    end
    if (bus_initialize) begin
      next_dir = '0; // R11
      next_ie = 1'b0; // R14
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dir <= '0;
      ie <= 1'b0;
    end else begin
      dir <= next_dir;
      ie <= next_ie;
    end
  end

  // ==========================================================================
  // Output path: two-entry buffer, then the port's output latch.
  // ==========================================================================
  logic [NP-1:0] dn_valid, drain_rdy, load, full, next_full, next_strobe;
  logic [NP-1:0][DW-1:0] dn_data, latch, next_latch;

  for (genvar p = 0; p < NP; p++) begin : g_port // R1
    qpp_stream_if #(.W(DW)) up_if ();
    qpp_stream_if #(.W(DW)) dn_if ();
    assign up_if.valid = push[p];
    assign up_if.data = reg_wdata;
    assign up_ready[p] = up_if.ready;
    assign dn_valid[p] = dn_if.valid;
    assign dn_data[p] = dn_if.data;
    assign dn_if.ready = drain_rdy[p];
    qpp_pair_buf #(.W(DW), .DEPTH(qpp_pkg::BUF_DEPTH)) u_buf (
      .core_clk(core_clk),
      .reset(reset),
      .up(up_if.snk),
      .dn(dn_if.src)
    );
    assign port_doe[p] = {DW{dir[p] & urdy_s2[p]}}; // R12 R13
  end

  assign drain_rdy = dir & urdy_s2 & ~full; // R16
  assign load = dn_valid & drain_rdy;
  assign port_dout = latch; // R2
  assign near_side_ready = ~dir; // R11 R17

  always_comb begin
    next_latch = latch;
    for (int p = 0; p < NP; p++) begin
      if (load[p]) begin
        next_latch[p] = dn_data[p]; // R2
      end
    end
    next_full = (full & ~ustb_rise) | load; // R17
    next_strobe = load;
  end

  // Bus initialize is deliberately absent here so the latches hold their data.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      latch <= '0;
      full <= '0;
      data_strobe <= '0;
    end else begin
      latch <= next_latch; // R7
      full <= next_full;
      data_strobe <= next_strobe;
    end
  end

  // ==========================================================================
  // Interrupt groups: command byte on ports A/C, data byte on ports B/D.
  // ==========================================================================
  logic [1:0][7:0] cmd, next_cmd, grp_stat, grp_data;
  logic [DW-1:0] req, irq_in_service_reg, auto_clear_reg, irq_mask_reg, next_req, next_isr, next_acr, next_imr, pend;
  logic [DW-1:0][7:0] vec, next_vec;
  logic [4:0] pick, gpick;
  logic [3:0] irq_idx, next_idx;
  logic next_irq, ack_take;
  logic [7:0] next_vector;
  qpp_pkg::qpp_target_e tgt;

  assign pend = req & ~irq_mask_reg & ~irq_in_service_reg;
  assign pick = qpp_pkg::qpp_lowest(pend); // R9
  assign ack_take = irq_ack & irq_req;

  always_comb begin
    grp_stat = '0;
    grp_data = '0;
    gpick = '0;
    tgt = qpp_pkg::QPP_T_REQ;
    for (int g = 0; g < qpp_pkg::NGRP; g++) begin
      gpick = qpp_pkg::qpp_lowest({8'h00, pend[g*8 +: 8]}); // R8
      grp_stat[g] = {gpick[4], 4'h0, gpick[2:0]}; // R10
      tgt = qpp_pkg::qpp_target_e'(cmd[g][qpp_pkg::CMD_SEL_LSB +: 3]);
      unique case (tgt) // R18
        qpp_pkg::QPP_T_REQ: grp_data[g] = req[g*8 +: 8];
        qpp_pkg::QPP_T_ISR: grp_data[g] = irq_in_service_reg[g*8 +: 8];
        qpp_pkg::QPP_T_ACR: grp_data[g] = auto_clear_reg[g*8 +: 8];
        qpp_pkg::QPP_T_IMR: grp_data[g] = irq_mask_reg[g*8 +: 8];
        qpp_pkg::QPP_T_VEC: grp_data[g] = vec[{1'(g), cmd[g][qpp_pkg::CMD_IDX_LSB +: 3]}];
        default: grp_data[g] = 8'h00;
      endcase
    end
  end

  always_comb begin
    next_cmd = cmd;
    next_req = req;
    next_isr = irq_in_service_reg;
    next_acr = auto_clear_reg;
    next_imr = irq_mask_reg;
    next_vec = vec;
    if (ack_take) begin
      next_req[irq_idx] = 1'b0;
      next_isr[irq_idx] = ~auto_clear_reg[irq_idx];
    end
    for (int g = 0; g < qpp_pkg::NGRP; g++) begin
      if (csr_wr[2*g] && reg_be[0]) begin
        next_cmd[g] = reg_wdata[7:0]; // R10
      end
      if (csr_wr[2*g+1] && reg_be[0]) begin
        unique case (cmd[g][qpp_pkg::CMD_SEL_LSB +: 3]) // R18
          3'h0: next_req[g*8 +: 8] = reg_wdata[7:0];
          3'h1: next_isr[g*8 +: 8] = reg_wdata[7:0];
          3'h2: next_acr[g*8 +: 8] = reg_wdata[7:0];
          3'h3: next_imr[g*8 +: 8] = reg_wdata[7:0];
          3'h4: next_vec[{1'(g), cmd[g][qpp_pkg::CMD_IDX_LSB +: 3]}] = reg_wdata[7:0];
          default: next_vec = vec;
        endcase
      end
    end
    next_req = next_req | req_edge; // R9
    next_irq = ie & pick[4] & ~ack_take; // R14
    next_idx = pick[3:0];
    next_vector = vec[pick[3:0]];
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cmd <= '0;
      req <= qpp_pkg::WORD_RST;
      irq_in_service_reg <= qpp_pkg::WORD_RST;
      auto_clear_reg <= qpp_pkg::WORD_RST;
      irq_mask_reg <= qpp_pkg::IMR_RST;
      vec <= '0;
      irq_req <= 1'b0;
      irq_idx <= 4'h0;
      irq_vector <= qpp_pkg::BYTE_RST;
    end else begin
      cmd <= next_cmd;
      req <= next_req;
      irq_in_service_reg <= next_isr;
      auto_clear_reg <= next_acr;
      irq_mask_reg <= next_imr;
      vec <= next_vec;
      irq_req <= next_irq;
      irq_idx <= next_idx;
      irq_vector <= next_vector;
    end
  end

  // ==========================================================================
  // Read-back path.
  // ==========================================================================
  logic [DW-1:0] rd_word, next_rdata;
  logic next_rvalid;

  always_comb begin
    rd_word = '0; // R19
    if (is_dbr) begin
      rd_word = dir[sel_p] ? latch[sel_p] : din_s2[sel_p]; // R2 R6
    end else begin
      rd_word[qpp_pkg::BIT_RDY] = urdy_s2[sel_p]; // R15
      rd_word[qpp_pkg::BIT_DIR] = dir[sel_p];
      rd_word[qpp_pkg::BIT_IE] = (sel_p == 2'h0) & ie;
      rd_word[7:0] = sel_p[0] ? grp_data[sel_p[1]] : grp_stat[sel_p[1]]; // R3 R4
    end
    next_rdata = reg_rd ? rd_word : reg_rdata;
    next_rvalid = reg_rd;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= qpp_pkg::WORD_RST;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end

  // ==========================================================================
  // Checks.
  // ==========================================================================
  logic rd_rdy, rd_csr, rd_out;
  logic [DW-1:0] rd_latch;
  assign rd_rdy = urdy_s2[sel_p];
  assign rd_csr = reg_rd & ~is_dbr;
  assign rd_out = reg_rd & is_dbr & dir[sel_p];
  assign rd_latch = latch[sel_p];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_init_clears_ctl: assert property (bus_initialize |=> dir == '0 && !ie // R11
    && near_side_ready == 4'hf) else $error("initialize left direction or enable set");
  a_drive_gating: assert property ((port_doe[1] != '0) == (dir[1] && urdy_s2[1])) // R12
    else $error("port drive not tied to direction and ready");
  a_release_lines: assert property (!dir[2] || !urdy_s2[2] |-> port_doe[2] == '0) // R13
    else $error("port drives while not in output mode");
  a_latch_kept: assert property (bus_initialize && load == '0 |=> latch == $past(latch)) // R7
    else $error("latch changed across initialize");
  a_ready_bit: assert property (rd_csr |=> reg_rvalid && reg_rdata[15] == $past(rd_rdy)) // R15
    else $error("ready bit does not follow user ready");
  a_unused_zero: assert property (rd_csr |=> reg_rdata[14:10] == 5'h00) // R19
    else $error("unused control bits read nonzero");
  a_out_readback: assert property (rd_out |=> reg_rdata == $past(rd_latch)) // R6
    else $error("output mode read differs from latch");
  a_irq_enable: assert property (irq_req |-> $past(ie)) // R14
    else $error("interrupt raised with enable clear");
  a_word_only: assert property (reg_wr && is_dbr && reg_be != 2'h3 |-> push == '0) // R5
    else $error("partial data buffer write accepted");
  a_req_set_wins: assert property (req_edge != '0 |=> (req & $past(req_edge)) == $past(req_edge))
    else $error("request edge lost"); // R9
  a_cmd_kept: assert property (bus_initialize && !reg_wr |=> cmd == $past(cmd)) // R10
    else $error("command byte changed on initialize");

  c_output_word: cover property (push[0] ##[1:20] data_strobe[0]);
  c_stall: cover property (reg_wr && is_dbr && !reg_wready);
  c_irq_ack: cover property (irq_req ##1 ack_take);
  c_init_read: cover property (bus_initialize ##1 reg_rvalid);

endmodule

/* tb/qpp_user_model.sv */
// ============================================================================
// User device on the far side of the four parallel ports.
// ============================================================================
module qpp_user_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [3:0] want_ready,
  input wire logic slow,
  input wire logic [3:0][15:0] in_word,
  input wire logic [3:0] data_strobe,
  input wire logic [3:0][15:0] port_dout,
  input wire logic [3:0][15:0] port_doe,
  output logic [3:0] user_ready,
  output logic [3:0] user_strobe,
  output logic [3:0][15:0] port_din,
  output logic [3:0][3:0] rx_cnt,
  output logic [15:0] rx_log [0:3][0:7]
);
  timeunit 1ns;
  timeprecision 1ps;

  int wait_cnt [4];

  // The device raises ready whenever it wants the port to output a word.
  assign user_ready = want_ready;
  // A line carries the port's latch while enabled and the device's word otherwise.
  assign port_din = (port_doe & port_dout) | (~port_doe & in_word);

  // Each received word is logged, then acknowledged after a short or long delay.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      user_strobe <= 4'h0;
      rx_cnt <= '0;
      for (int p = 0; p < 4; p++) begin
        wait_cnt[p] <= 0;
      end
    end else begin
      for (int p = 0; p < 4; p++) begin
        if (data_strobe[p]) begin
          rx_log[p][rx_cnt[p][2:0]] <= port_dout[p];
          rx_cnt[p] <= rx_cnt[p] + 4'h1;
          wait_cnt[p] <= slow ? 8 : 3;
        end else if (wait_cnt[p] > 0) begin
          wait_cnt[p] <= wait_cnt[p] - 1;
        end
        user_strobe[p] <= (wait_cnt[p] == 1) || (wait_cnt[p] == 2);
      end
    end
  end
endmodule

/* tb/test_quad_parallel_port_csr.sv */
module test_quad_parallel_port_csr;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk, reset, bus_initialize, reg_wr, reg_rd, reg_wready, reg_rvalid;
  logic [2:0] reg_addr;
  logic [1:0] reg_be;
  logic [15:0] reg_wdata, reg_rdata;
  logic [3:0][15:0] port_din, port_dout, port_doe, in_word;
  logic [3:0] user_ready, user_strobe, near_side_ready, data_strobe, want_ready;
  logic irq_ack, irq_req, slow;
  logic [7:0] irq_vector;
  logic [3:0][3:0] rx_cnt;
  logic [15:0] rx_log [0:3][0:7];
  logic [7:0] cmd_tab [5] = '{8'h02, 8'h03, 8'h0c, 8'h04, 8'h05};
  logic [7:0] val_tab [5] = '{8'ha5, 8'hfe, 8'h77, 8'h3c, 8'h99};
  int num_errors = 0;
  int checked = 0;

  qpp_top dut (.core_clk(core_clk), .reset(reset), .bus_initialize(bus_initialize),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_be(reg_be),
    .reg_wdata(reg_wdata), .reg_wready(reg_wready), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .port_din(port_din), .port_dout(port_dout),
    .port_doe(port_doe), .user_ready(user_ready), .user_strobe(user_strobe),
    .near_side_ready(near_side_ready), .data_strobe(data_strobe), .irq_ack(irq_ack),
    .irq_req(irq_req), .irq_vector(irq_vector));

  qpp_user_model u_user (.core_clk(core_clk), .reset(reset), .want_ready(want_ready),
    .slow(slow), .in_word(in_word), .data_strobe(data_strobe), .port_dout(port_dout),
    .port_doe(port_doe), .user_ready(user_ready), .user_strobe(user_strobe),
    .port_din(port_din), .rx_cnt(rx_cnt), .rx_log(rx_log));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ==========================================================================
  // Reporting and host access tasks.
  // ==========================================================================
  task automatic summarize();
    $display("mismatches %0d of %0d checks", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic hang(input string name);
    num_errors++;
    $display("wrong value %s expected done seen timeout", name);
    summarize();
  endtask

  // Ends on a falling edge so that outputs are looked at once they have settled.
  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic wr(input logic [2:0] a, input logic [1:0] be, input logic [15:0] d);
    logic ok;
    ok = 1'b0;
    @(posedge core_clk);
    reg_addr <= a;
    reg_be <= be;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    for (int i = 0; i < 60 && !ok; i++) begin
      @(negedge core_clk);
      ok = (reg_wready === 1'b1);
      @(posedge core_clk);
    end
    reg_wr <= 1'b0;
    if (!ok) hang("reg_wready");
  endtask

  task automatic rchk(input logic [2:0] a, input logic [15:0] exp, input string name);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    if (reg_rvalid !== 1'b1) hang("reg_rvalid");
    check(name, reg_rdata, exp);
  endtask

  task automatic wait_rx(input int p, input logic [3:0] n);
    int i;
    for (i = 0; i < 80; i++) begin
      @(negedge core_clk);
      if (rx_cnt[p] === n) break;
    end
    if (i == 80) hang("rx_cnt");
  endtask

  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial begin
    reset = 1'b1;
    bus_initialize = 1'b0;
    reg_addr = 3'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_be = 2'h0;
    reg_wdata = 16'h0000;
    irq_ack = 1'b0;
    want_ready = 4'h0;
    slow = 1'b0;
    in_word = '0;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    cycles(2);
    check("near_side_ready", {12'h000, near_side_ready}, 16'h000f);
    check("port_doe", {15'h0000, |port_doe}, 16'h0000);
    rchk(3'h0, 16'h0000, "csr_a");
    wr(3'h0, 2'h2, 16'hfc00);
    rchk(3'h0, 16'h0000, "csr_a_unused");
    @(posedge core_clk) want_ready <= 4'h1;
    cycles(4);
    rchk(3'h0, 16'h8000, "csr_a_ready");
    @(posedge core_clk) want_ready <= 4'h0;
    for (int i = 0; i < 5; i++) begin
      wr(3'h0, 2'h1, {8'h00, cmd_tab[i]});
      wr(3'h1, 2'h1, {8'h00, val_tab[i]});
    end
    for (int i = 0; i < 5; i++) begin
      wr(3'h0, 2'h1, {8'h00, cmd_tab[i]});
      rchk(3'h1, {8'h00, (i == 4) ? 8'h00 : val_tab[i]}, "group_reg");
    end
    // Line 0 is unmasked and auto-cleared, line 1 stays masked.
    wr(3'h0, 2'h1, 16'h0004);
    @(posedge core_clk) in_word[0] <= 16'h0003;
    cycles(8);
    check("irq_req_off", {15'h0000, irq_req}, 16'h0000);
    wr(3'h0, 2'h2, 16'h0200);
    for (int i = 0; i < 10 && irq_req !== 1'b1; i++) @(negedge core_clk);
    check("irq_req_on", {15'h0000, irq_req}, 16'h0001);
    check("irq_vector", {8'h00, irq_vector}, 16'h003c);
    rchk(3'h0, 16'h0280, "csr_a_status");
    @(posedge core_clk) irq_ack <= 1'b1;
    @(posedge core_clk) irq_ack <= 1'b0;
    cycles(3);
    check("irq_req_ack", {15'h0000, irq_req}, 16'h0000);
    for (int p = 1; p < 4; p++) begin
      wr({1'b0, 2'(p)}, 2'h2, 16'h0100);
      @(posedge core_clk) want_ready[p] <= 1'b1;
      wr({1'b1, 2'(p)}, 2'h3, 16'hc000 | 16'(p));
      wait_rx(p, 4'h1);
      check("rx_word", rx_log[p][0], 16'hc000 | 16'(p));
      check("port_doe_on", port_doe[p], 16'hffff);
      rchk({1'b1, 2'(p)}, 16'hc000 | 16'(p), "dbr_latch");
      check("near_ready_out", {15'h0000, near_side_ready[p]}, 16'h0000);
    end
    @(posedge core_clk) want_ready[1] <= 1'b0;
    cycles(4);
    check("port_doe_off", port_doe[1], 16'h0000);
    rchk(3'h1, 16'h013c, "csr_b");
    wr(3'h5, 2'h3, 16'ha001);
    wr(3'h5, 2'h3, 16'ha002);
    @(negedge core_clk);
    check("reg_wready_full", {15'h0000, reg_wready}, 16'h0000);
    @(posedge core_clk);
    slow <= 1'b1;
    want_ready[1] <= 1'b1;
    wr(3'h5, 2'h3, 16'ha003);
    wait_rx(1, 4'h4);
    for (int i = 1; i < 4; i++) begin
      check("rx_order", rx_log[1][i], 16'ha000 | 16'(i));
    end
    @(posedge core_clk) bus_initialize <= 1'b1;
    @(posedge core_clk) bus_initialize <= 1'b0;
    cycles(3);
    check("near_ready_init", {12'h000, near_side_ready}, 16'h000f);
    check("port_doe_init", {15'h0000, |port_doe}, 16'h0000);
    check("latch_init", port_dout[1], 16'ha003);
    rchk(3'h0, 16'h0000, "csr_a_init");
    rchk(3'h1, 16'h803c, "csr_b_init");
    wr(3'h0, 2'h1, 16'h0000);
    rchk(3'h1, 16'h8002, "irq_request");
    wr(3'h2, 2'h1, 16'h0003);
    rchk(3'h3, 16'h80ff, "group2_mask");
    @(posedge core_clk) in_word[1] <= 16'h5aa5;
    cycles(4);
    rchk(3'h5, 16'h5aa5, "dbr_pins");
    wr(3'h5, 2'h1, 16'hdead);
    wr(3'h1, 2'h2, 16'h0100);
    cycles(12);
    check("rx_cnt_byte", {12'h000, rx_cnt[1]}, 16'h0004);
    check("latch_byte", port_dout[1], 16'ha003);
    summarize();
  end
endmodule
